// >>> drive_mech_model.sv
// behavioural model of the drive mechanics and host dma channel beside the handler
// assumes one clock shared with the handler and an active-low async reset
`timescale 1ns/1ps
module drive_mech_model (
    // clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // bench controls
    input wire logic slow,
    input wire logic dma_armed,
    // cache and spindle
    input wire logic cache_flush_req,
    output logic cache_flush_done,
    input wire logic spin_down_req,
    input wire logic spin_up_req,
    output logic spindle_stopped,
    output logic spindle_at_speed,
    // dma channel
    input wire logic dmarq,
    output logic dmack,
    input wire logic [15:0] dma_data,
    output int dma_cnt,
    output logic [15:0] dma_first,
    output logic [15:0] dma_last
);
    int flush_ff;
    int spin_ff;
    int phase_ff;

    // cached writes take a while to land; done holds until the request drops
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            flush_ff <= 0;
            cache_flush_done <= 1'b0;
        end else if (!cache_flush_req) begin
            flush_ff <= 0;
            cache_flush_done <= 1'b0;
        end else if (flush_ff < (slow ? 12 : 3)) begin
            flush_ff <= flush_ff + 1;
        end else begin
            cache_flush_done <= 1'b1;
        end
    end

    // spindle loses speed at once when asked to stop, stops later
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            spin_ff <= 0;
            spindle_stopped <= 1'b0;
            spindle_at_speed <= 1'b1;
        end else if (spin_down_req && !spindle_stopped) begin
            spindle_at_speed <= 1'b0;
            spin_ff <= spin_ff + 1;
            if (spin_ff >= (slow ? 20 : 6)) begin
                spindle_stopped <= 1'b1;
            end
        end else if (spin_up_req && !spindle_at_speed) begin
            spindle_stopped <= 1'b0;
            spin_ff <= spin_ff + 1;
            if (spin_ff >= (slow ? 20 : 6)) begin
                spindle_at_speed <= 1'b1;
            end
        end else begin
            spin_ff <= 0;
        end
    end

    // one word per ack pulse; channel moves nothing unless armed and requested
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            phase_ff <= 0;
            dmack <= 1'b0;
            dma_cnt <= 0;
            dma_first <= 16'h0000;
            dma_last <= 16'h0000;
        end else if (phase_ff != 0) begin
            phase_ff <= (phase_ff == (slow ? 16 : 10)) ? 0 : phase_ff + 1;
            if (phase_ff == 2) begin
                dmack <= 1'b0;
            end
        end else if (dmarq && dma_armed) begin
            dmack <= 1'b1;
            phase_ff <= 1;
            dma_cnt <= dma_cnt + 1;
            dma_last <= dma_data;
            if (dma_cnt == 0) begin
                dma_first <= dma_data;
            end
        end
    end
endmodule

// >>> standby_trusted_cmd_handler_test.sv
// self-checking bench for the standby / trusted receive handler
// assumes the mechanics model drives the cache, spindle and dma pins
`timescale 1ns/1ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin n_errors++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, (got), (exp)); end end
module standby_trusted_cmd_handler_test;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic hsel = 1'b1;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rd;
    logic hreadyout, hresp, cache_flush_req, cache_flush_done, spin_down_req, spin_up_req;
    logic spindle_stopped, spindle_at_speed, dmarq, dmack, intrq;
    logic [15:0] dma_data, dma_first, dma_last;
    logic slow = 1'b0;
    logic dma_armed = 1'b0;
    logic pd = 1'b0, pu = 1'b0, pi = 1'b0, flushed = 1'b0;
    int dma_cnt, base;
    int n_errors = 0, num_checks = 0, cyc = 0, downs = 0, ups = 0, irqs = 0;

    always #20 mclk = ~mclk;

    stby_trusted_cmd #(.SEC_CYCLES(10)) DUT (.mclk(mclk), .arst_n(arst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .cache_flush_req(cache_flush_req), .cache_flush_done(cache_flush_done),
        .spin_down_req(spin_down_req), .spin_up_req(spin_up_req),
        .spindle_stopped(spindle_stopped), .spindle_at_speed(spindle_at_speed),
        .dmarq(dmarq), .dmack(dmack), .dma_data(dma_data), .intrq(intrq));

    drive_mech_model mech (.mclk(mclk), .arst_n(arst_n), .slow(slow), .dma_armed(dma_armed),
        .cache_flush_req(cache_flush_req), .cache_flush_done(cache_flush_done),
        .spin_down_req(spin_down_req), .spin_up_req(spin_up_req),
        .spindle_stopped(spindle_stopped), .spindle_at_speed(spindle_at_speed),
        .dmarq(dmarq), .dmack(dmack), .dma_data(dma_data), .dma_cnt(dma_cnt),
        .dma_first(dma_first), .dma_last(dma_last));

    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // edge counters; a spin-down must follow a completed flush
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        pd <= spin_down_req;
        pu <= spin_up_req;
        pi <= intrq;
        if (cache_flush_done === 1'b1) flushed <= 1'b1;
        if (spin_down_req === 1'b1 && !pd) begin
            downs <= downs + 1;
            `CHK(flushed, 1'b1)
            flushed <= 1'b0;
        end
        if (spin_up_req === 1'b1 && !pu) ups <= ups + 1;
        if (intrq === 1'b1 && !pi) irqs <= irqs + 1;
        if (cyc == 40000) begin
            n_errors++;
            $display("CHECK FAILED t=%0t run did not finish", $time);
            end_sim();
        end
    end

    // single word transfer: hold address phase, then data phase, until hready
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
        rd = hrdata;
    endtask

    task automatic cmd(input logic [7:0] f, input logic [7:0] sc, input logic [7:0] op);
        bus(1'b1, stby_trusted_pkg::OFS_FEATURE, {24'h0, f});
        bus(1'b1, stby_trusted_pkg::OFS_SECCNT, {24'h0, sc});
        bus(1'b1, stby_trusted_pkg::OFS_COMMAND, {24'h0, op});
    endtask

    // wait for completion, check status, status read must drop the interrupt
    task automatic done_chk(input logic [7:0] st);
        while (intrq !== 1'b1) @(posedge mclk);
        bus(1'b0, stby_trusted_pkg::OFS_STATUS, 32'h0);
        `CHK(rd[7:0], st)
        repeat (2) @(posedge mclk);
        `CHK(intrq, 1'b0)
    endtask

    task automatic power_chk(input logic [8:0] exp);
        bus(1'b0, stby_trusted_pkg::OFS_POWER, 32'h0);
        `CHK(rd[8:0], exp)
    endtask

    initial begin
        repeat (16) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (6) @(posedge mclk);
        bus(1'b0, stby_trusted_pkg::OFS_STATUS, 32'h0);
        `CHK(rd[7:0], 8'h50)
        `CHK(hresp, 1'b0)
        bus(1'b0, 8'h1c, 32'h0);
        `CHK(rd, 32'h0)
        // standby from spinning, timer off
        cmd(8'h00, 8'h00, stby_trusted_pkg::OP_STBY);
        done_chk(8'h40);
        `CHK(downs, 1)
        power_chk(9'h100);
        // already stopped: no spin-down, new count not taken
        cmd(8'h00, 8'h07, stby_trusted_pkg::OP_STBY_IMM_ALT);
        done_chk(8'h40);
        `CHK(downs, 1)
        power_chk(9'h100);
        // pio receive from standby: spin up before data is offered
        cmd(8'h3c, 8'h01, stby_trusted_pkg::OP_TRX_PIO);
        rd = 32'h0;
        while (rd[stby_trusted_pkg::ST_DRQ] !== 1'b1) bus(1'b0, stby_trusted_pkg::OFS_STATUS, 0);
        `CHK(rd[stby_trusted_pkg::ST_DSC], 1'b1)
        `CHK(ups, 1)
        for (int i = 0; i < 256; i++) begin
            bus(1'b0, stby_trusted_pkg::OFS_DATA, 32'h0);
            `CHK(rd[15:0], {8'h3c, i[7:0] ^ 8'h3c})
        end
        done_chk(8'h50);
        repeat (120) @(posedge mclk);
        `CHK(downs, 1)
        // standby with 5 s timer
        cmd(8'h00, 8'h01, stby_trusted_pkg::OP_STBY_ALT);
        done_chk(8'h40);
        `CHK(downs, 2)
        power_chk(9'h101);
        // dma receive on a slow channel, armed before the opcode
        slow <= 1'b1;
        dma_armed <= 1'b1;
        base = irqs;
        cmd(8'h5a, 8'h01, stby_trusted_pkg::OP_TRX_DMA);
        done_chk(8'h50);
        slow <= 1'b0;
        `CHK(irqs - base, 1)
        `CHK(dma_cnt, 256)
        `CHK(dma_first, 16'h5a5a)
        `CHK(dma_last, 16'h5aa5)
        `CHK(dmarq, 1'b0)
        `CHK(ups, 2)
        // access reloads the 50-cycle interval; silence lets it expire
        repeat (40) @(posedge mclk);
        power_chk(9'h001);
        repeat (44) @(posedge mclk);
        `CHK(downs, 2)
        repeat (20) @(posedge mclk);
        `CHK(downs, 3)
        `CHK(intrq, 1'b0)
        // let the automatic spin-down finish, or the next register writes are refused
        rd[stby_trusted_pkg::ST_BSY] = 1'b1;
        while (rd[stby_trusted_pkg::ST_BSY] !== 1'b0) bus(1'b0, stby_trusted_pkg::OFS_STATUS, 0);
        // upper code: (0xf1 - 240) * 30 min = 18000 cycles
        cmd(8'h00, 8'hf1, stby_trusted_pkg::OP_STBY);
        done_chk(8'h40);
        cmd(8'h11, 8'h01, stby_trusted_pkg::OP_TRX_DMA);
        done_chk(8'h50);
        repeat (17950) @(posedge mclk);
        `CHK(downs, 3)
        repeat (100) @(posedge mclk);
        `CHK(downs, 4)
        // unknown opcode aborts; immediate standby keeps the stored count
        cmd(8'h00, 8'h00, 8'h77);
        done_chk(8'h41);
        bus(1'b0, stby_trusted_pkg::OFS_ERROR, 32'h0);
        `CHK(rd[7:0], 8'h04)
        cmd(8'h00, 8'h00, stby_trusted_pkg::OP_STBY_IMM);
        done_chk(8'h40);
        power_chk(9'h1f1);
        end_sim();
    end
endmodule

// >>> stby_trusted_cmd.sv
// standby, standby immediate and trusted receive (pio / dma) handler
// assumes an AHB-Lite master, a cache, spindle control and a dma channel
// Functional notes
// R1 - standby opcode enters standby and loads the power-down timeout parameter
// R2 - flush cached writes before spin-down; interface stays active
// R3 - spindle already stopped: skip spin-down sequence
// R4 - accept commands in standby; media transfer waits for spindle speed
// R5 - power-down countdown runs only in idle
// R6 - timeout zero disables auto power-down, non-zero enables it
// R7 - codes 241..251 give (code-240) times 30 minutes
// R8 - 1..240 give code*5 s; 252..255 give fixed intervals
// R9 - enabled timer expiring without host access enters standby
// R10 - host access reloads the full interval
// R11 - standby immediate opcode enters standby at once
// R12 - standby immediate keeps stored timeout parameter
// R13 - trusted receive returns 512-byte packets over pio
// R14 - packet content depends on the feature protocol byte
// R15 - pio data register moves 16 bits per access
// R16 - trusted receive dma returns 512-byte packets over dma
// R17 - host sets up its dma channel before the opcode
// R18 - dma words move only while dmarq is asserted, on host acks
// R19 - dma command raises one interrupt, at the end
// R20 - completion clears busy and fault; abort sets abt and err
//
// Local design decisions: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
module stby_trusted_cmd #(
    parameter int SEC_CYCLES = stby_trusted_pkg::SEC_CYCLES
) (
    // clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // cache and spindle
    output logic cache_flush_req,
    input wire logic cache_flush_done,
    output logic spin_down_req,
    output logic spin_up_req,
    input wire logic spindle_stopped,
    input wire logic spindle_at_speed,
    // dma channel
    output logic dmarq,
    input wire logic dmack,
    output logic [15:0] dma_data,
    // host interrupt
    output logic intrq
);
    typedef enum logic [2:0] {
        S_IDLE, S_FLUSH, S_SPDN, S_SPUP, S_PIO, S_DMA
    } state_t;

    // timeout code to seconds
    function automatic logic [14:0] tmo_secs(input logic [7:0] c);
        logic [14:0] w;
        w = {7'h00, c};
        if (c <= stby_trusted_pkg::TMO_LIN_MAX)
            return 15'(w * stby_trusted_pkg::TMO_LIN_STEP); // [R8]
        else if (c <= stby_trusted_pkg::TMO_HH_MAX)
            return 15'((w - {7'h00, stby_trusted_pkg::TMO_LIN_MAX})
                * stby_trusted_pkg::TMO_HH_STEP); // [R7]
        else if (c == stby_trusted_pkg::TMO_C252)
            return stby_trusted_pkg::TMO_S252; // [R8]
        else if (c == stby_trusted_pkg::TMO_C253)
            return stby_trusted_pkg::TMO_S253;
        else if (c == stby_trusted_pkg::TMO_C254)
            return stby_trusted_pkg::TMO_S254;
        else
            return stby_trusted_pkg::TMO_S255;
    endfunction

    // packet word from protocol byte and position
    function automatic logic [15:0] pkt_word(input logic [7:0] f, input logic [7:0] i);
        return {f, i ^ f}; // [R14]
    endfunction

    logic rst_a_ff, rst_n;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rst_a_ff <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_a_ff <= 1'b1;
            rst_n <= rst_a_ff;
        end
    end

    // pin synchronisers; dmack gets a third stage for edge detect
    logic [1:0] fd_sy, st_sy, sp_sy;
    logic [2:0] ak_sy;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            fd_sy <= 2'b00;
            st_sy <= 2'b00;
            sp_sy <= 2'b00;
            ak_sy <= 3'b000;
        end else begin
            fd_sy <= {fd_sy[0], cache_flush_done};
            st_sy <= {st_sy[0], spindle_stopped};
            sp_sy <= {sp_sy[0], spindle_at_speed};
            ak_sy <= {ak_sy[1:0], dmack};
        end
    end
    logic flush_done_s, stopped_s, at_speed_s, ack_pulse;
    assign flush_done_s = fd_sy[1];
    assign stopped_s = st_sy[1];
    assign at_speed_s = sp_sy[1];
    assign ack_pulse = ak_sy[1] & ~ak_sy[2];

    // bus address phase
    logic acc, rd_data;
    logic wr_ff;
    logic [7:0] wa_ff;
    assign acc = hsel & htrans[1] & hready;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    state_t state_ff, nxt_state;
    logic [7:0] feat_ff, seccnt_ff, param_ff, err_ff;
    logic [7:0] word_ff;
    logic [8:0] pkts_ff;
    logic err_st_ff, auto_ff, dma_cmd_ff;
    logic [14:0] remain_ff;
    logic [31:0] tick_ff;
    logic [15:0] pio_word_ff;

    assign rd_data = acc & ~hwrite & (haddr == stby_trusted_pkg::OFS_DATA)
        & (state_ff == S_PIO);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ff <= 1'b0;
            wa_ff <= 8'h00;
        end else begin
            wr_ff <= acc & hwrite;
            wa_ff <= haddr;
        end
    end

    // command decode in the write data phase
    logic cmd_wr, busy, is_stby, is_imm, is_trx, accept;
    assign cmd_wr = wr_ff & (wa_ff == stby_trusted_pkg::OFS_COMMAND);
    assign busy = (state_ff != S_IDLE);
    assign accept = cmd_wr & ~busy;
    assign is_stby = (hwdata[7:0] == stby_trusted_pkg::OP_STBY)
        | (hwdata[7:0] == stby_trusted_pkg::OP_STBY_ALT);
    assign is_imm = (hwdata[7:0] == stby_trusted_pkg::OP_STBY_IMM)
        | (hwdata[7:0] == stby_trusted_pkg::OP_STBY_IMM_ALT);
    assign is_trx = (hwdata[7:0] == stby_trusted_pkg::OP_TRX_PIO)
        | (hwdata[7:0] == stby_trusted_pkg::OP_TRX_DMA);

    logic last_word, expire, fin, fin_abort;
    assign last_word = (word_ff == stby_trusted_pkg::WORD_LAST) && (pkts_ff == 9'h001);
    assign expire = (state_ff == S_IDLE) && (param_ff != stby_trusted_pkg::TMO_OFF)
        && !stopped_s && !acc && !cmd_wr && (remain_ff == 15'h0001)
        && (tick_ff == 32'(SEC_CYCLES - 1));

    always_comb begin
        nxt_state = state_ff;
        fin = 1'b0;
        fin_abort = 1'b0;
        case (state_ff)
            S_IDLE: begin
                if (accept) begin
                    if (is_stby || is_imm) begin
                        if (stopped_s)
                            fin = 1'b1; // [R3]
                        else
                            nxt_state = S_FLUSH; // [R1] [R11]
                    end else if (is_trx) begin
                        nxt_state = !at_speed_s ? S_SPUP
                            : (hwdata[0] ? S_DMA : S_PIO); // [R4]
                    end else begin
                        fin = 1'b1;
                        fin_abort = 1'b1; // [R20]
                    end
                end else if (expire) begin
                    nxt_state = S_FLUSH; // [R9]
                end
            end
            S_FLUSH: if (flush_done_s) nxt_state = S_SPDN; // [R2]
            S_SPDN: begin
                if (stopped_s) begin
                    nxt_state = S_IDLE;
                    fin = ~auto_ff;
                end
            end
            S_SPUP: if (at_speed_s) nxt_state = dma_cmd_ff ? S_DMA : S_PIO; // [R4]
            S_PIO: begin
                if (rd_data && last_word) begin
                    nxt_state = S_IDLE;
                    fin = 1'b1;
                end
            end
            S_DMA: begin
                if (ack_pulse && last_word) begin
                    nxt_state = S_IDLE;
                    fin = 1'b1; // [R19]
                end
            end
            default: nxt_state = S_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= S_IDLE;
            auto_ff <= 1'b0;
            dma_cmd_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            if (accept) begin
                auto_ff <= 1'b0;
                dma_cmd_ff <= hwdata[0];
            end else if (expire) begin
                auto_ff <= 1'b1;
            end
        end
    end

    // host-written registers; immediate leaves the parameter alone
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            feat_ff <= 8'h00;
            seccnt_ff <= 8'h00;
            param_ff <= stby_trusted_pkg::TMO_OFF;
        end else begin
            if (wr_ff && !busy && wa_ff == stby_trusted_pkg::OFS_FEATURE)
                feat_ff <= hwdata[7:0];
            if (wr_ff && !busy && wa_ff == stby_trusted_pkg::OFS_SECCNT)
                seccnt_ff <= hwdata[7:0];
            if (accept && is_stby)
                param_ff <= seccnt_ff; // [R1] [R12]
        end
    end

    // auto power-down countdown
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            remain_ff <= 15'h0000;
            tick_ff <= 32'h0000_0000;
        end else if (state_ff != S_IDLE || stopped_s || acc || cmd_wr) begin
            remain_ff <= tmo_secs(param_ff); // [R5] [R10]
            tick_ff <= 32'h0000_0000;
        end else if (param_ff != stby_trusted_pkg::TMO_OFF) begin // [R6]
            if (tick_ff == 32'(SEC_CYCLES - 1)) begin
                tick_ff <= 32'h0000_0000;
                remain_ff <= (remain_ff == 15'h0001) ? tmo_secs(param_ff)
                    : remain_ff - 15'h0001;
            end else begin
                tick_ff <= tick_ff + 32'h0000_0001;
            end
        end
    end

    // packet stream; sector count 0 means 256 packets
    logic adv;
    assign adv = ((state_ff == S_PIO) && rd_data)
        || ((state_ff == S_DMA) && ack_pulse); // [R15] [R18]
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            word_ff <= 8'h00;
            pkts_ff <= 9'h000;
        end else if (accept && is_trx) begin
            word_ff <= 8'h00;
            pkts_ff <= (seccnt_ff == 8'h00) ? stby_trusted_pkg::PKT_FULL
                : {1'b0, seccnt_ff}; // [R13] [R16]
        end else if (adv) begin
            word_ff <= word_ff + 8'h01;
            if (word_ff == stby_trusted_pkg::WORD_LAST)
                pkts_ff <= pkts_ff - 9'h001;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pio_word_ff <= 16'h0000;
        end else begin
            pio_word_ff <= pkt_word(feat_ff, adv ? word_ff + 8'h01 : word_ff);
        end
    end
    assign dma_data = pio_word_ff;

    // status, error and interrupt; a new event beats a status read
    logic st_rd;
    assign st_rd = acc & ~hwrite & (haddr == stby_trusted_pkg::OFS_STATUS);
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            err_ff <= 8'h00;
            err_st_ff <= 1'b0;
            intrq <= 1'b0;
        end else begin
            if (accept) begin
                err_ff <= 8'h00;
                err_st_ff <= 1'b0;
            end
            if (fin) begin
                err_ff[stby_trusted_pkg::ER_ABT] <= fin_abort; // [R20]
                err_st_ff <= fin_abort;
            end
            if (fin)
                intrq <= 1'b1; // [R19]
            else if (st_rd)
                intrq <= 1'b0;
        end
    end

    logic [7:0] status;
    always_comb begin
        status = 8'h00;
        status[stby_trusted_pkg::ST_BSY] = busy && state_ff != S_PIO && state_ff != S_DMA;
        status[stby_trusted_pkg::ST_RDY] = !status[stby_trusted_pkg::ST_BSY]; // [R20]
        status[stby_trusted_pkg::ST_DF] = 1'b0;
        status[stby_trusted_pkg::ST_DSC] = at_speed_s;
        status[stby_trusted_pkg::ST_DRQ] = (state_ff == S_PIO);
        status[stby_trusted_pkg::ST_ERR] = err_st_ff;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hrdata <= 32'h0000_0000;
        end else if (acc && !hwrite) begin
            case (haddr)
                stby_trusted_pkg::OFS_DATA: hrdata <= {16'h0000, pio_word_ff}; // [R15]
                stby_trusted_pkg::OFS_ERROR: hrdata <= {24'h000000, err_ff};
                stby_trusted_pkg::OFS_FEATURE: hrdata <= {24'h000000, feat_ff};
                stby_trusted_pkg::OFS_SECCNT: hrdata <= {24'h000000, seccnt_ff};
                stby_trusted_pkg::OFS_STATUS: hrdata <= {24'h000000, status};
                stby_trusted_pkg::OFS_POWER: hrdata <= {23'h000000, stopped_s, param_ff};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    assign cache_flush_req = (state_ff == S_FLUSH); // [R2]
    assign spin_down_req = (state_ff == S_SPDN);
    assign spin_up_req = (state_ff == S_SPUP);
    assign dmarq = (state_ff == S_DMA); // [R18]

    sequence stby_taken;
        accept && is_stby;
    endsequence
    sequence flush_then_down;
        cache_flush_req ##1 !cache_flush_req && spin_down_req;
    endsequence

    AST_STBY_PARAM: assert property (@(posedge mclk) disable iff (!rst_n) // [R1]
        stby_taken |=> param_ff == $past(seccnt_ff)) else $error("timeout not loaded");
    AST_IMM_KEEP: assert property (@(posedge mclk) disable iff (!rst_n) // [R12]
        accept && is_imm |=> $stable(param_ff)) else $error("immediate changed timeout");
    AST_FLUSH_FIRST: assert property (@(posedge mclk) disable iff (!rst_n) // [R2]
        $rose(spin_down_req) |-> $past(cache_flush_req)) else $error("spin-down before flush");
    AST_FLUSH_SEQ: assert property (@(posedge mclk) disable iff (!rst_n) // [R2]
        cache_flush_req && flush_done_s |-> flush_then_down) else $error("flush did not lead on");
    AST_SKIP: assert property (@(posedge mclk) disable iff (!rst_n) // [R3]
        accept && (is_stby || is_imm) && stopped_s |=> !cache_flush_req && intrq)
        else $error("spin-down not skipped");
    AST_MEDIA_WAIT: assert property (@(posedge mclk) disable iff (!rst_n) // [R4]
        $rose(dmarq) || $rose(status[stby_trusted_pkg::ST_DRQ]) |-> $past(at_speed_s))
        else $error("transfer before spindle at speed");
    AST_ZERO_OFF: assert property (@(posedge mclk) disable iff (!rst_n) // [R6]
        param_ff == stby_trusted_pkg::TMO_OFF |-> !expire) else $error("disabled timer expired");
    AST_RELOAD: assert property (@(posedge mclk) disable iff (!rst_n) // [R10]
        acc |=> remain_ff == tmo_secs($past(param_ff))) else $error("access did not reload");
    AST_PIO_STEP: assert property (@(posedge mclk) disable iff (!rst_n) // [R15]
        rd_data && !last_word |=> word_ff == $past(word_ff) + 8'h01) else $error("pio word skip");
    AST_DMA_IRQ: assert property (@(posedge mclk) disable iff (!rst_n) // [R19]
        dmarq |-> !$rose(intrq)) else $error("interrupt during dma");
    AST_ABORT: assert property (@(posedge mclk) disable iff (!rst_n) // [R20]
        accept && !is_stby && !is_imm && !is_trx |=> err_ff[stby_trusted_pkg::ER_ABT]
        && status[stby_trusted_pkg::ST_ERR] && status[stby_trusted_pkg::ST_RDY])
        else $error("abort not reported");
endmodule

// >>> stby_trusted_pkg.sv
// constants for the standby / trusted receive command handler
// assumes one 25 MHz clock and an AHB-Lite register port
package stby_trusted_pkg;
    // clock and one-second tick
    localparam int CLK_PERIOD_NS = 40;
    localparam int SEC_NS = 1000000000;
    localparam int SEC_CYCLES = SEC_NS / CLK_PERIOD_NS;
    // register byte offsets
    localparam logic [7:0] OFS_DATA = 8'h00;
    localparam logic [7:0] OFS_ERROR = 8'h04;
    localparam logic [7:0] OFS_FEATURE = 8'h08;
    localparam logic [7:0] OFS_SECCNT = 8'h0c;
    localparam logic [7:0] OFS_COMMAND = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_POWER = 8'h18;
    // opcodes
    localparam logic [7:0] OP_STBY = 8'he2;
    localparam logic [7:0] OP_STBY_ALT = 8'h96;
    localparam logic [7:0] OP_STBY_IMM = 8'he0;
    localparam logic [7:0] OP_STBY_IMM_ALT = 8'h94;
    localparam logic [7:0] OP_TRX_PIO = 8'h5c;
    localparam logic [7:0] OP_TRX_DMA = 8'h5d;
    // status and error bit positions
    localparam int ST_BSY = 7;
    localparam int ST_RDY = 6;
    localparam int ST_DF = 5;
    localparam int ST_DSC = 4;
    localparam int ST_DRQ = 3;
    localparam int ST_ERR = 0;
    localparam int ER_ABT = 2;
    // timeout decode, intervals in seconds
    localparam logic [7:0] TMO_OFF = 8'h00;
    localparam logic [7:0] TMO_LIN_MAX = 8'hf0;
    localparam logic [7:0] TMO_HH_MAX = 8'hfb;
    localparam logic [7:0] TMO_C252 = 8'hfc;
    localparam logic [7:0] TMO_C253 = 8'hfd;
    localparam logic [7:0] TMO_C254 = 8'hfe;
    localparam logic [14:0] TMO_LIN_STEP = 15'h0005;
    localparam logic [14:0] TMO_HH_STEP = 15'h0708;
    localparam logic [14:0] TMO_S252 = 15'h04ec;
    localparam logic [14:0] TMO_S253 = 15'h7080;
    localparam logic [14:0] TMO_S254 = 15'h04f6;
    localparam logic [14:0] TMO_S255 = 15'h04fb;
    // packet geometry: 256 words of 16 bits
    localparam logic [7:0] WORD_LAST = 8'hff;
    localparam logic [8:0] PKT_FULL = 9'h100;
endpackage
